// ### pa_pulse_source.sv
`timescale 1ns/10ps
`default_nettype none
module pa_pulse_source (
  input wire logic sys_clk,
  output logic pinOut
);
  // ======================================================
  // accumulator input pin driver
  // shorter levels may vanish inside the input synchronisers
  localparam int MIN_HOLD = 3;
  initial pinOut = 1'b1;
  task automatic drive(input logic level, input int hold);
    @(posedge sys_clk);
    pinOut <= level;
    repeat ((hold < MIN_HOLD) ? MIN_HOLD : hold) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### pa_timer_pkg.sv
// Overview of operation
// [RQ1] Accumulator enable switches the whole accumulator, independent of timer enable.
// [RQ2] Mode bit: zero counts events, one accumulates gated time.
// [RQ3] Event mode counts falling edges with edge select zero, rising with one.
// [RQ4] Gated mode counts divide-by-64 ticks while pin at level; trailing edge flags.
// [RQ5] Divide-by-64 ticks exist only while the main timer runs.
// [RQ6] Clock select picks prescaler, accumulator clock, its /256 or /65536.
// [RQ7] Accumulator disabled: main counter always uses the prescaler clock.
// [RQ8] Clock selection change acts immediately on write.
// [RQ9] Each flag raises its request only when its enable bit is one.
// [RQ10] With fast clear set, any count register access clears all flags.
// [RQ11] Overflow flag sets on wrap from all ones; write one to bit 1 clears.
// [RQ12] Edge flag sets on selected edge; write one to bit 0 clears.
// [RQ13] Software accesses the count as one word in a single transfer.
// [RQ14] Test register always readable, writable in special mode; timer bypass bit.
// [RQ15] Accumulator bypass splits counter into two 8-bit halves clocked directly.
// [RQ16] Port read gives pin level for inputs, driver level for outputs.
// [RQ17] Port latch writes never alter a pin driven by compare output.
// [RQ18] Accumulator input pulses last longer than two module clocks.
// [RQ19] Direction bit zero is input, one output; all reset to zero.
// [RQ20] Enabled compare forces pin output; direction bit kept; captures never override.
// [RQ21] Timer stops in stop mode, in debug or wait only with freeze bits.
// [RQ22] Timer or accumulator disabled stops operation; registers stay accessible. Timer disabled: accumulator clock selects still drive timerCountTick.
package pa_timer_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL = 10'h0A0;
  localparam logic [9:0] IDX_FLAGS = 10'h0A1;
  localparam logic [9:0] IDX_COUNT = 10'h0A2;
  localparam logic [9:0] IDX_SYSCTL = 10'h0A6;
  localparam logic [9:0] IDX_TEST = 10'h0AD;
  localparam logic [9:0] IDX_PORTDATA = 10'h0AE;
  localparam logic [9:0] IDX_DIRECTION = 10'h0AF;
  // ==========================================================
  // control field positions
  localparam int CTL_ENABLE = 6;
  localparam int CTL_MODE = 5;
  localparam int CTL_EDGE = 4;
  localparam int CTL_CLKSEL_HI = 3;
  localparam int CTL_CLKSEL_LO = 2;
  localparam int CTL_OVF_IE = 1;
  localparam int CTL_EDGE_IE = 0;
  localparam int FLG_OVF = 1;
  localparam int FLG_EDGE = 0;
  localparam int SYS_TIMER_EN = 7;
  localparam int SYS_WAIT_FRZ = 6;
  localparam int SYS_DEBUG_FRZ = 5;
  localparam int SYS_FAST_CLR = 4;
  localparam int TST_TIMER_BYP = 1;
  localparam int TST_ACCUM_BYP = 0;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_SYSCTL = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_PORTDATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [5:0] DIV64_LAST = 6'h3F;
  localparam logic [1:0] CLK_PRESCALER = 2'h0;
  localparam logic [1:0] CLK_ACCUM = 2'h1;
  localparam logic [1:0] CLK_ACCUM_256 = 2'h2;
  localparam logic [1:0] CLK_ACCUM_64K = 2'h3;
  localparam int ACCUM_PIN = 7;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DATA = 2'b11,
    BUS_WR_DATA = 2'b10
  } bus_state_t;
endpackage

// ### pulse_accumulator_timer_port.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_accumulator_timer_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] portIn,
  output logic [7:0] portOut,
  output logic [7:0] portOe,
  input wire logic [7:0] compareEnable,
  input wire logic [7:0] compareLevel,
  input wire logic prescalerTick,
  input wire logic stopMode,
  input wire logic debugMode,
  input wire logic waitMode,
  input wire logic specialModeN,
  output logic timerCountTick,
  output logic timerChainBypass,
  output logic timerRun,
  output logic accumOverflowIrq,
  output logic accumEdgeIrq
);
  import pa_timer_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] control_r;
  logic [7:0] sysctl_r;
  logic [7:0] test_r;
  logic [7:0] portLatch_r;
  logic [7:0] direction_r;
  logic [15:0] count_r;
  logic overflowFlag_r;
  logic edgeFlag_r;
  logic [31:0] hrdata_r;
  bus_state_t busState_r;
  bus_state_t busState_nxt;
  logic [9:0] addrIdx_r;
  logic [5:0] div64_r;
  logic pinSync1_r;
  logic pinSync2_r;
  logic pinPrev_r;

  logic accumEnable;
  logic accumModeSelect;
  logic accumEdgeSelect;
  logic [1:0] clockSelect;
  logic accumRun;
  logic div64Tick;
  logic risingEdge;
  logic fallingEdge;
  logic countEdge;
  logic gateOpen;
  logic trailingEdge;
  logic accumClock;
  logic countWrap;
  logic lowWrap;
  logic addrAccept;
  logic wrEn;
  logic countAccess;
  logic fastClear;
  logic [7:0] portDrive;
  logic [7:0] portReadback;
  logic [31:0] readMux;

  assign accumEnable = control_r[CTL_ENABLE];
  assign accumModeSelect = control_r[CTL_MODE];
  assign accumEdgeSelect = control_r[CTL_EDGE];
  assign clockSelect = {control_r[CTL_CLKSEL_HI], control_r[CTL_CLKSEL_LO]};

  // ==========================================================
  // run conditions
  assign timerRun = sysctl_r[SYS_TIMER_EN] && !stopMode &&
    !(debugMode && sysctl_r[SYS_DEBUG_FRZ]) &&
    !(waitMode && sysctl_r[SYS_WAIT_FRZ]); // RQ21 RQ22
  // accumulator freezes with the timer's low-power conditions too
  assign accumRun = accumEnable && !stopMode &&
    !(debugMode && sysctl_r[SYS_DEBUG_FRZ]) &&
    !(waitMode && sysctl_r[SYS_WAIT_FRZ]); // RQ1 RQ22
  assign timerChainBypass = test_r[TST_TIMER_BYP]; // RQ14

  // ==========================================================
  // divide-by-64 time base, part of the timer prescaler
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div64_r <= 6'h00;
    end else if (timerRun) begin // RQ5
      div64_r <= div64_r + 6'h01;
    end
  end
  assign div64Tick = timerRun && (div64_r == DIV64_LAST); // RQ5

  // ==========================================================
  // input pin synchroniser; edges compare the second stage with pinPrev_r, the first stage is never examined
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinSync1_r <= 1'b0;
      pinSync2_r <= 1'b0;
      pinPrev_r <= 1'b0;
    end else begin
      pinSync1_r <= portIn[ACCUM_PIN]; // RQ18
      pinSync2_r <= pinSync1_r;
      pinPrev_r <= pinSync2_r;
    end
  end
  assign risingEdge = pinSync2_r && !pinPrev_r;
  assign fallingEdge = !pinSync2_r && pinPrev_r;
  assign countEdge = accumEdgeSelect ? risingEdge : fallingEdge; // RQ3
  // gate level is high for edge select 0 and low for 1
  assign gateOpen = (pinSync2_r != accumEdgeSelect); // RQ4
  assign trailingEdge = accumEdgeSelect ? risingEdge : fallingEdge; // RQ4
  assign accumClock = accumRun && (accumModeSelect ?
    (gateOpen && div64Tick) : countEdge); // RQ2 RQ3 RQ4

  // in bypass both halves step together with no carry between them
  assign lowWrap = accumClock && (count_r[7:0] == 8'hFF);
  assign countWrap = test_r[TST_ACCUM_BYP] ?
    (accumClock && (count_r[15:8] == 8'hFF)) :
    (accumClock && (count_r == 16'hFFFF)); // RQ11 RQ15

  // ==========================================================
  // main timer clock selection, purely combinational for no delay
  always_comb begin
    if (!accumEnable || clockSelect == CLK_PRESCALER) begin // RQ7
      // bypass skips the prescaler: every running cycle ticks
      timerCountTick = timerRun &&
        (test_r[TST_TIMER_BYP] || prescalerTick); // RQ14
    end else begin
      case (clockSelect) // RQ6 RQ8
        CLK_ACCUM: timerCountTick = accumClock;
        CLK_ACCUM_256: timerCountTick = lowWrap;
        CLK_ACCUM_64K: timerCountTick = accumClock &&
          (count_r == 16'hFFFF);
        default: timerCountTick = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // AHB-Lite slave: writes take no wait state, reads one
  assign addrAccept = hsel && htrans[1] && hready;
  assign wrEn = (busState_r == BUS_WR_DATA);
  assign countAccess = addrAccept && (haddr[11:2] == IDX_COUNT);
  assign fastClear = countAccess && sysctl_r[SYS_FAST_CLR]; // RQ10
  assign hreadyout = (busState_r != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_comb begin
    busState_nxt = busState_r;
    case (busState_r)
      BUS_RD_WAIT: busState_nxt = BUS_RD_DATA;
      BUS_IDLE, BUS_RD_DATA, BUS_WR_DATA: begin
        if (addrAccept) begin
          busState_nxt = hwrite ? BUS_WR_DATA : BUS_RD_WAIT;
        end else begin
          busState_nxt = BUS_IDLE;
        end
      end
      default: busState_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busState_r <= BUS_IDLE;
      addrIdx_r <= 10'h000;
    end else begin
      busState_r <= busState_nxt;
      if (addrAccept) begin
        addrIdx_r <= haddr[11:2];
      end
    end
  end

  // ==========================================================
  // readback
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // outputs reflect the driver input, inputs the pin
      portReadback[i] = portOe[i] ? portDrive[i] : portIn[i]; // RQ16
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (addrIdx_r)
      IDX_CONTROL: readMux[7:0] = control_r;
      IDX_FLAGS: begin
        readMux[FLG_OVF] = overflowFlag_r;
        readMux[FLG_EDGE] = edgeFlag_r;
      end
      IDX_COUNT: readMux[15:0] = count_r; // RQ13
      IDX_SYSCTL: readMux[7:0] = sysctl_r;
      IDX_TEST: readMux[7:0] = test_r; // RQ14
      IDX_PORTDATA: readMux[7:0] = portReadback; // RQ16
      IDX_DIRECTION: readMux[7:0] = direction_r;
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (busState_r == BUS_RD_WAIT) begin
      hrdata_r <= readMux;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_r <= RST_CONTROL;
      sysctl_r <= RST_SYSCTL;
      direction_r <= RST_DIRECTION; // RQ19
      portLatch_r <= RST_PORTDATA;
    end else if (wrEn) begin
      case (addrIdx_r)
        IDX_CONTROL: control_r <= {1'b0, hwdata[6:0]}; // RQ8
        IDX_SYSCTL: sysctl_r <= {hwdata[7:4], 4'h0};
        IDX_DIRECTION: direction_r <= hwdata[7:0]; // RQ19
        IDX_PORTDATA: portLatch_r <= hwdata[7:0]; // RQ16
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_r <= RST_TEST;
    end else if (wrEn && addrIdx_r == IDX_TEST && !specialModeN) begin
      test_r <= {6'h00, hwdata[1:0]}; // RQ14
    end
  end

  // ==========================================================
  // accumulator count; a software write wins over a count step
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_r <= RST_COUNT;
    end else if (wrEn && addrIdx_r == IDX_COUNT) begin
      count_r <= hwdata[15:0]; // RQ13 RQ22
    end else if (accumClock) begin
      if (test_r[TST_ACCUM_BYP]) begin
        count_r <= {count_r[15:8] + 8'h01,
          count_r[7:0] + 8'h01}; // RQ15
      end else begin
        count_r <= count_r + 16'h0001; // RQ2
      end
    end
  end

  // ==========================================================
  // flags: a hardware set in the clearing cycle survives
  logic flagWrite;
  assign flagWrite = wrEn && (addrIdx_r == IDX_FLAGS);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflowFlag_r <= 1'b0;
    end else if (countWrap) begin
      overflowFlag_r <= 1'b1; // RQ11
    end else if ((flagWrite && hwdata[FLG_OVF]) || fastClear) begin
      overflowFlag_r <= 1'b0; // RQ11 RQ10
    end
  end

  logic edgeEvent;
  assign edgeEvent = accumRun && (accumModeSelect ?
    trailingEdge : countEdge); // RQ12

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edgeFlag_r <= 1'b0;
    end else if (edgeEvent) begin
      edgeFlag_r <= 1'b1; // RQ12
    end else if ((flagWrite && hwdata[FLG_EDGE]) || fastClear) begin
      edgeFlag_r <= 1'b0; // RQ12 RQ10
    end
  end

  assign accumOverflowIrq = overflowFlag_r && control_r[CTL_OVF_IE]; // RQ9
  assign accumEdgeIrq = edgeFlag_r && control_r[CTL_EDGE_IE]; // RQ9

  // ==========================================================
  // port pins: compare outputs override direction and latch
  assign portDrive = (compareEnable & compareLevel) |
    (~compareEnable & portLatch_r); // RQ17
  assign portOe = direction_r | compareEnable; // RQ20
  assign portOut = portDrive; // RQ16

  // ==========================================================
  // checks
  AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (rst)
    accumClock && !wrEn && !test_r[TST_ACCUM_BYP] |=>
      count_r == $past(count_r) + 16'h0001) // RQ2
    else $error("count did not step on accumulator clock");

  AST_ACCUM_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !accumEnable |-> !accumClock && !edgeEvent) // RQ1
    else $error("accumulator active while disabled");

  AST_EVENT_EDGE: assert property (@(posedge sys_clk) disable iff (rst)
    accumRun && !accumModeSelect && !accumEdgeSelect &&
      $fell(pinSync2_r) |-> accumClock) // RQ3
    else $error("falling edge not counted");

  AST_GATED_TIMER: assert property (@(posedge sys_clk) disable iff (rst)
    accumModeSelect && !timerRun |-> !accumClock) // RQ5
    else $error("gated count without running timer");

  AST_PRESCALER_PATH: assert property (@(posedge sys_clk)
    disable iff (rst)
    !accumEnable |-> timerCountTick ==
      (timerRun && (test_r[TST_TIMER_BYP] || prescalerTick))) // RQ7
    else $error("timer clock not from prescaler");

  // a count write in the wrap cycle wins, so it is left out
  AST_OVF_SET: assert property (@(posedge sys_clk) disable iff (rst)
    countWrap && !(wrEn && addrIdx_r == IDX_COUNT) |=>
      overflowFlag_r && count_r[15:8] == 8'h00) // RQ11
    else $error("overflow flag missing after wrap");

  AST_FAST_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    fastClear && !countWrap && !edgeEvent |=>
      !overflowFlag_r && !edgeFlag_r) // RQ10
    else $error("fast clear left a flag set");

  AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (rst)
    edgeEvent && control_r[CTL_EDGE_IE] && !wrEn |=> accumEdgeIrq) // RQ9
    else $error("edge request missing after enabled edge");

  AST_EDGE_SET: assert property (@(posedge sys_clk) disable iff (rst)
    edgeEvent |=> edgeFlag_r) // RQ12
    else $error("edge flag missing after selected edge");

  AST_COMPARE_PIN: assert property (@(posedge sys_clk) disable iff (rst)
    compareEnable[0] |-> portOe[0] && portOut[0] == compareLevel[0]) // RQ17
    else $error("compare output not driving pin");

  AST_TEST_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
    specialModeN |=> $stable(test_r)) // RQ14
    else $error("test register changed outside special mode");

  AST_READ_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
    addrAccept && !hwrite |=> !hreadyout ##1 hreadyout) // RQ22
    else $error("read answer not after one wait state");

  COV_OVERFLOW: cover property (@(posedge sys_clk) disable iff (rst)
    countWrap ##1 accumOverflowIrq);
  COV_GATED: cover property (@(posedge sys_clk) disable iff (rst)
    accumModeSelect && accumClock ##[1:200] edgeEvent);
  COV_FAST_CLEAR: cover property (@(posedge sys_clk) disable iff (rst)
    edgeFlag_r && fastClear ##1 !edgeFlag_r);
  COV_DIV256: cover property (@(posedge sys_clk) disable iff (rst)
    accumEnable && clockSelect == CLK_ACCUM_256 && timerCountTick);
  COV_SPLIT: cover property (@(posedge sys_clk) disable iff (rst)
    test_r[TST_ACCUM_BYP] && accumClock);
endmodule
`default_nettype wire

// ### pulse_accumulator_timer_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, expv, got) begin testsRun++; if ((got) !== (expv)) begin \
  nMismatch++; $display("BAD %s expected %h seen %h", nm, expv, got); end end
module pulse_accumulator_timer_port_tb;
  import pa_timer_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, pin, tickOn, prescalerTick;
  logic stopMode, debugMode, waitMode, specialModeN, timerCountTick;
  logic timerChainBypass, timerRun, ovfIrq, edgeIrq;
  logic [31:0] haddr, hwdata, hrdata, rd, gated;
  logic [1:0] htrans;
  logic [7:0] portLow, portOut, portOe, cmpEn, cmpLvl;
  int nMismatch = 0;
  int testsRun = 0;
  int tickCnt = 0;
  int t0, ec;
  logic [9:0] rstRegs[6] = '{IDX_CONTROL, IDX_FLAGS, IDX_COUNT, IDX_SYSCTL,
    IDX_DIRECTION, 10'h0A3};
  // ctl, sysctl, {stop,debug,wait}, expected ticks per 100 cycles
  logic [31:0] modes[9] = '{32'h0080_0032, 32'h4480_0000, 32'h0880_0032,
    32'h0080_0400, 32'h0080_0232, 32'h00A0_0200, 32'h0080_0132,
    32'h00C0_0100, 32'h0000_0000};

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) prescalerTick <= tickOn & ~prescalerTick;
  always @(posedge sys_clk) if (timerCountTick === 1'b1) tickCnt++;

  pulse_accumulator_timer_port u_pulse_accumulator_timer_port (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .portIn({pin, portLow[6:0]}), .portOut(portOut), .portOe(portOe),
    .compareEnable(cmpEn), .compareLevel(cmpLvl),
    .prescalerTick(prescalerTick), .stopMode(stopMode),
    .debugMode(debugMode), .waitMode(waitMode), .specialModeN(specialModeN),
    .timerCountTick(timerCountTick), .timerChainBypass(timerChainBypass),
    .timerRun(timerRun), .accumOverflowIrq(ovfIrq), .accumEdgeIrq(edgeIrq)
  );
  pa_pulse_source u_pa_pulse_source (.sys_clk(sys_clk), .pinOut(pin));

  // ======================================================
  // bus access and reporting
  task summarize;
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task waitReady;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      nMismatch++;
      summarize();
    end
  endtask
  task bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask
  task wr(input logic [9:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task rdChk(input string nm, input logic [9:0] idx, input logic [31:0] ex);
    bus(1'b0, idx, 32'h0);
    `CHK(nm, ex, rd)
  endtask
  task ticks(input string nm, input int ex);
    @(posedge sys_clk);
    #1;
    t0 = tickCnt;
    repeat (100) @(posedge sys_clk);
    #1;
    `CHK(nm, ex, tickCnt - t0)
  endtask
  task endTest(input string nm);
    $display("test %s done, mismatches so far %0d", nm, nMismatch);
  endtask

  // ======================================================
  // hang guard
  initial begin
    #400000;
    nMismatch++;
    summarize();
  end

  // ======================================================
  // main sequence
  initial begin
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    portLow = 8'h3C; cmpEn = 0; cmpLvl = 0; tickOn = 0;
    stopMode = 0; debugMode = 0; waitMode = 0; specialModeN = 1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rstRegs[i]) rdChk("reset", rstRegs[i], 32'h0);
    rdChk("port in", IDX_PORTDATA, 32'hBC);
    `CHK("okay", 1'b0, hresp)
    endTest("reset");
    wr(IDX_TEST, 32'h3);
    rdChk("test locked", IDX_TEST, 32'h0);
    specialModeN <= 1'b0;
    wr(IDX_TEST, 32'h3);
    rdChk("test open", IDX_TEST, 32'h3);
    `CHK("bypass pin", 1'b1, timerChainBypass)
    wr(IDX_SYSCTL, 32'h80);
    ticks("bypass ticks", 100);
    `CHK("timer run", 1'b1, timerRun)
    wr(IDX_TEST, 32'h0);
    endTest("test register");
    tickOn <= 1'b1;
    foreach (modes[i]) begin
      wr(IDX_CONTROL, {24'h0, modes[i][31:24]});
      wr(IDX_SYSCTL, {24'h0, modes[i][23:16]});
      {stopMode, debugMode, waitMode} <= modes[i][10:8];
      ticks("clock select", int'(modes[i][7:0]));
    end
    {stopMode, debugMode, waitMode} <= 3'h0;
    endTest("clock select");
    ec = 0;
    for (int e = 0; e < 2; e++) begin
      wr(IDX_CONTROL, 32'h40 | (e << 4));
      u_pa_pulse_source.drive(1'b0, 5);
      if (e == 0) ec++;
      rdChk("count fall", IDX_COUNT, ec);
      u_pa_pulse_source.drive(1'b1, 5);
      if (e == 1) ec++;
      rdChk("count rise", IDX_COUNT, ec);
    end
    rdChk("edge flag", IDX_FLAGS, 32'h1);
    `CHK("edge irq off", 1'b0, edgeIrq)
    wr(IDX_CONTROL, 32'h51);
    // the write lands on the edge just passed; let it settle
    #1;
    `CHK("edge irq on", 1'b1, edgeIrq)
    wr(IDX_FLAGS, 32'h2);
    rdChk("wrong clear", IDX_FLAGS, 32'h1);
    wr(IDX_FLAGS, 32'h1);
    rdChk("edge clear", IDX_FLAGS, 32'h0);
    `CHK("edge irq clr", 1'b0, edgeIrq)
    wr(IDX_CONTROL, 32'h10);
    u_pa_pulse_source.drive(1'b0, 5);
    u_pa_pulse_source.drive(1'b1, 5);
    rdChk("disabled", IDX_COUNT, ec);
    endTest("event mode");
    wr(IDX_CONTROL, 32'h52);
    wr(IDX_COUNT, 32'hFFFF);
    u_pa_pulse_source.drive(1'b0, 5);
    u_pa_pulse_source.drive(1'b1, 5);
    rdChk("wrap", IDX_COUNT, 32'h0);
    rdChk("both flags", IDX_FLAGS, 32'h3);
    `CHK("ovf irq", 1'b1, ovfIrq)
    wr(IDX_FLAGS, 32'h2);
    rdChk("ovf clear", IDX_FLAGS, 32'h1);
    `CHK("ovf irq clr", 1'b0, ovfIrq)
    wr(IDX_SYSCTL, 32'h10);
    rdChk("fast count", IDX_COUNT, 32'h0);
    rdChk("fast clear", IDX_FLAGS, 32'h0);
    wr(IDX_SYSCTL, 32'h0);
    wr(IDX_TEST, 32'h1);
    wr(IDX_CONTROL, 32'h50);
    u_pa_pulse_source.drive(1'b0, 5);
    u_pa_pulse_source.drive(1'b1, 5);
    rdChk("split", IDX_COUNT, 32'h0101);
    wr(IDX_TEST, 32'h0);
    specialModeN <= 1'b1;
    for (int s = 2; s < 4; s++) begin
      wr(IDX_CONTROL, 32'h50 | (s << 2));
      wr(IDX_COUNT, (s == 2) ? 32'hFF : 32'hFFFF);
      t0 = tickCnt;
      u_pa_pulse_source.drive(1'b0, 5);
      u_pa_pulse_source.drive(1'b1, 5);
      `CHK("carry clock", 1, tickCnt - t0)
    end
    endTest("overflow");
    wr(IDX_CONTROL, 32'h0);
    wr(IDX_SYSCTL, 32'h80);
    u_pa_pulse_source.drive(1'b0, 5);
    wr(IDX_COUNT, 32'h0);
    wr(IDX_FLAGS, 32'h3);
    wr(IDX_CONTROL, 32'h61);
    u_pa_pulse_source.drive(1'b1, 640);
    u_pa_pulse_source.drive(1'b0, 5);
    bus(1'b0, IDX_COUNT, 32'h0);
    gated = rd;
    `CHK("gated", 1'b1, gated >= 32'd9 && gated <= 32'd11)
    rdChk("gate flag", IDX_FLAGS, 32'h1);
    wr(IDX_SYSCTL, 32'h0);
    u_pa_pulse_source.drive(1'b1, 640);
    u_pa_pulse_source.drive(1'b0, 5);
    rdChk("no timer", IDX_COUNT, gated);
    endTest("gated mode");
    wr(IDX_DIRECTION, 32'h0F);
    wr(IDX_PORTDATA, 32'hA5);
    #1;
    `CHK("oe", 8'h0F, portOe)
    `CHK("drive", 8'hA5, portOut)
    rdChk("port mix", IDX_PORTDATA, 32'h35);
    cmpEn <= 8'h10;
    cmpLvl <= 8'h10;
    wr(IDX_PORTDATA, 32'h0);
    `CHK("cmp oe", 8'h1F, portOe)
    `CHK("cmp out", 1'b1, portOut[4])
    rdChk("dir kept", IDX_DIRECTION, 32'h0F);
    cmpEn <= 8'h0;
    @(posedge sys_clk);
    #1;
    `CHK("oe back", 8'h0F, portOe)
    endTest("port");
    summarize();
  end
endmodule
`default_nettype wire
